// ---- bench/lcsp_liu_model.sv ----
// Line interface unit model on the far side of the control and status port.
// Assumes the bench commands the lock state of each channel.
`timescale 1ns/1ns
module lcsp_liu_model #(
    parameter int CH = 6
) (
    input  wire logic                             clk_sys,
    input  wire lcsp_pkg::lcsp_liu_ctl_t [CH-1:0] liu_ctl,
    input  wire logic [CH-1:0]                    locked,
    output logic [CH-1:0]                         rx_lock_lost_in
);
    // ----------------------------------------------------------------
    // Line side
    // ----------------------------------------------------------------
    logic [CH-1:0] coder_on;
    logic [CH-1:0] shaped;
    always_comb begin
        for (int c = 0; c < CH; c++) begin
            coder_on[c] = ~liu_ctl[c].encoder_disable_out;
            shaped[c]   = ~liu_ctl[c].buildout_select_out;
        end
    end
    // lock indicator
    // Moving it on the clock edge is harmless, the port resynchronises it.
    always_ff @(posedge clk_sys) begin
        rx_lock_lost_in <= ~locked;
    end
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the line interface control and status port.
// Assumes the line unit model drives the lock lost inputs.
`timescale 1ns/1ns
module testbench;
    localparam int CH = 6;
    logic                             clk_sys = 1'h0;
    logic                             reset = 1'h1;
    logic                             reg_wr = 1'h0;
    logic                             reg_rd = 1'h0;
    logic [7:0]                       reg_addr = 8'h00;
    logic [2:0]                       reg_chan = 3'h0;
    logic [7:0]                       reg_wdata = 8'h00;
    logic [7:0]                       reg_rdata;
    logic [7:0]                       d;
    logic [CH-1:0]                    locked = '1;
    logic [CH-1:0]                    rx_lock_lost_in;
    logic [CH-1:0]                    frame_lost = '0;
    logic [CH-1:0]                    hdlc_enable = '0;
    logic [CH-1:0]                    nib_update = '0;
    logic [CH-1:0][3:0]               nib_data = '0;
    logic [CH-1:0][3:0]               pkt_data = '0;
    lcsp_pkg::lcsp_liu_ctl_t [CH-1:0] liu_ctl;
    logic [CH-1:0]                    rx_frame_lost_flag;
    logic [CH-1:0][3:0]               rx_quad_bit_out;
    int                               failures = 0;
    int                               checks = 0;

    lcsp_port #(.CHANNELS(CH), .NIB_W(4)) dut (.clk_sys(clk_sys), .reset(reset),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_chan(reg_chan),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_lock_lost_in(rx_lock_lost_in),
        .frame_lost(frame_lost), .hdlc_enable(hdlc_enable), .nib_update(nib_update),
        .nib_data(nib_data), .pkt_data(pkt_data), .liu_ctl(liu_ctl),
        .rx_frame_lost_flag(rx_frame_lost_flag), .rx_quad_bit_out(rx_quad_bit_out));
    lcsp_liu_model #(.CH(CH)) liu (.clk_sys(clk_sys), .liu_ctl(liu_ctl),
        .locked(locked), .rx_lock_lost_in(rx_lock_lost_in));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // Each access leaves the bench one step after a clock edge.
    task automatic wr(input logic [2:0] c, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'h1;
        reg_chan <= c;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic rd(input logic [2:0] c, input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'h1;
        reg_chan <= c;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        @(posedge clk_sys);
        #1;
        d = reg_rdata;
    endtask
    function automatic logic [7:0] ctl(input int c);
        return {5'h00, liu_ctl[c]};
    endfunction
    task automatic stop_test();
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (2000) @(posedge clk_sys);
        failures++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'h0;
        rd(3'h0, lcsp_pkg::LCSP_OFS_DRIVE);
        chk("drive", 8'h00, d);
        for (int c = 0; c < CH; c++) chk("ctl", 8'h00, ctl(c));
        wr(3'h0, lcsp_pkg::LCSP_OFS_DRIVE, 8'h0a);
        chk("ctl0", 8'h06, ctl(0));
        chk("ctl1", 8'h00, ctl(1));
        chk("coder0", 8'h00, {7'h00, liu.coder_on[0]});
        wr(3'h5, lcsp_pkg::LCSP_OFS_DRIVE, 8'h04);
        chk("ctl5", 8'h01, ctl(5));
        chk("shaped5", 8'h00, {7'h00, liu.shaped[5]});
        chk("shaped0", 8'h01, {7'h00, liu.shaped[0]});
        rd(3'h0, lcsp_pkg::LCSP_OFS_DRIVE);
        chk("drive0", 8'h0a, d);
        wr(3'h0, lcsp_pkg::LCSP_OFS_DRIVE, 8'h00);
        wr(3'h0, lcsp_pkg::LCSP_OFS_SCAN, 8'hff);
        chk("ctl0", 8'h00, ctl(0));
        rd(3'h0, 8'h7f);
        chk("unmapped", 8'h00, d);
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk_sys);
            locked[3] <= ~v[0];
            frame_lost[1] <= v[0];
            rd(3'h2, lcsp_pkg::LCSP_OFS_SCAN);
            chk("scan2", 8'h00, d & 8'h02);
            chk("oof", {7'h00, v[0]}, {7'h00, rx_frame_lost_flag[1]});
            chk("oof0", 8'h00, {7'h00, rx_frame_lost_flag[0]});
            rd(3'h3, lcsp_pkg::LCSP_OFS_SCAN);
            chk("scan3", {6'h00, v[0], 1'h0}, d & 8'h02);
        end
        for (int h = 0; h < 2; h++) begin
            @(posedge clk_sys);
            hdlc_enable[4] <= h[0];
            nib_data[4] <= 4'h5;
            pkt_data[4] <= 4'h2;
            nib_update[4] <= 1'h1;
            @(posedge clk_sys);
            nib_update[4] <= 1'h0;
            nib_data[4] <= 4'ha;
            repeat (2) @(posedge clk_sys);
            #1;
            chk("nibble", h ? 8'h07 : 8'h05, {4'h0, rx_quad_bit_out[4]});
        end
        // A reset in mid-run must bring every output back to its start value.
        wr(3'h2, lcsp_pkg::LCSP_OFS_DRIVE, 8'h0e);
        chk("ctl2", 8'h07, ctl(2));
        @(posedge clk_sys);
        reset <= 1'h1;
        @(posedge clk_sys);
        reset <= 1'h0;
        #1;
        chk("ctl2", 8'h00, ctl(2));
        chk("oof1", 8'h01, {7'h00, rx_frame_lost_flag[1]});
        chk("nibble", 8'h00, {4'h0, rx_quad_bit_out[4]});
        rd(3'h2, lcsp_pkg::LCSP_OFS_DRIVE);
        chk("drive2", 8'h00, d);
        chk("oof1", 8'h00, {7'h00, rx_frame_lost_flag[1]});
        stop_test();
    end
endmodule

// ---- logic/lcsp_channel.sv ----
// One channel's drive register, scan input and receive status outputs.
// Assumes all inputs except lock lost arrive on clk_sys.
`timescale 1ns/1ns
module lcsp_channel #(
    parameter int NIB_W = lcsp_pkg::LCSP_NIBBLE_W
) (
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire logic                  drive_we,
    input  wire logic [7:0]            wdata,
    input  wire logic                  rx_lock_lost_in,
    input  wire logic                  frame_lost,
    input  wire logic                  hdlc_enable,
    input  wire logic                  nib_update,
    input  wire logic [NIB_W-1:0]      nib_data,
    input  wire logic [NIB_W-1:0]      pkt_data,
    output logic [7:0]                 drive_q,
    output logic [7:0]                 scan_q,
    output lcsp_pkg::lcsp_liu_ctl_t    liu_ctl,
    output logic                       rx_frame_lost_flag,
    output logic [NIB_W-1:0]           rx_quad_bit_out
);
    if (NIB_W <= lcsp_pkg::LCSP_PKT_BIT) begin : g_bad_width
        $error("lcsp_channel: nibble too narrow for the packet bit");
    end

    logic [7:0]       drive_ff,  nxt_drive;
    logic [1:0]       lol_ff,    nxt_lol;
    logic             oof_ff,    nxt_oof;
    logic [NIB_W-1:0] nib_ff,    nxt_nib;

    always_comb begin
        nxt_drive = drive_ff;
        if (drive_we) begin
            nxt_drive = wdata;
        end
        // Two stages because the lock signal comes from the unit's own clock.
        nxt_lol = {lol_ff[0], rx_lock_lost_in};
        nxt_oof = frame_lost;
        nxt_nib = nib_ff;
        if (nib_update) begin
            nxt_nib = nib_data;
            if (hdlc_enable) begin
                nxt_nib[lcsp_pkg::LCSP_PKT_BIT] = pkt_data[lcsp_pkg::LCSP_PKT_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            drive_ff <= lcsp_pkg::LCSP_DRIVE_RESET;
            lol_ff   <= '0;
            oof_ff   <= 1'b1;
            nib_ff   <= '0;
        end else begin
            drive_ff <= nxt_drive;
            lol_ff   <= nxt_lol;
            oof_ff   <= nxt_oof;
            nib_ff   <= nxt_nib;
        end
    end

    always_comb begin
        drive_q = drive_ff;
        scan_q  = 8'h00;
        scan_q[lcsp_pkg::LCSP_BIT_LOCKLOST] = lol_ff[1];
        liu_ctl.local_loopback_out  = drive_ff[lcsp_pkg::LCSP_BIT_LOOPBACK];
        liu_ctl.encoder_disable_out = drive_ff[lcsp_pkg::LCSP_BIT_ENCDIS];
        liu_ctl.buildout_select_out = drive_ff[lcsp_pkg::LCSP_BIT_BUILDOUT];
        rx_frame_lost_flag = oof_ff;
        rx_quad_bit_out    = nib_ff;
    end

    // The sampled reset in some antecedents keeps the release edge out, since
    // disable iff looks at the current reset level, already low at that edge.
    chk_loop_follows_write: assert property (@(posedge clk_sys) disable iff (reset)
        drive_we |=> liu_ctl.local_loopback_out == $past(wdata[lcsp_pkg::LCSP_BIT_LOOPBACK]))
        else $error("loopback output does not follow written bit");
    chk_encdis_follows: assert property (@(posedge clk_sys) disable iff (reset)
        drive_we |=> liu_ctl.encoder_disable_out == $past(wdata[lcsp_pkg::LCSP_BIT_ENCDIS]))
        else $error("encoder disable does not follow written bit");
    chk_scan_lock_bit: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(rx_lock_lost_in) ##1 rx_lock_lost_in ##1 rx_lock_lost_in
        |-> scan_q[lcsp_pkg::LCSP_BIT_LOCKLOST])
        else $error("lock lost not reported in scan register");
    chk_oof_tracks: assert property (@(posedge clk_sys) disable iff (reset)
        !reset && frame_lost |=> rx_frame_lost_flag)
        else $error("out of frame flag not raised");
    chk_oof_clears: assert property (@(posedge clk_sys) disable iff (reset)
        !reset && !frame_lost |=> !rx_frame_lost_flag)
        else $error("out of frame flag not cleared");
    chk_pkt_mux_bit: assert property (@(posedge clk_sys) disable iff (reset)
        nib_update && hdlc_enable
        |=> rx_quad_bit_out[lcsp_pkg::LCSP_PKT_BIT] == $past(pkt_data[lcsp_pkg::LCSP_PKT_BIT]))
        else $error("packet bit not on nibble bit 1");
    chk_nib_hold: assert property (@(posedge clk_sys) disable iff (reset)
        !reset && !nib_update |=> $stable(rx_quad_bit_out))
        else $error("nibble changed without update edge");
    chk_buildout_out: assert property (@(posedge clk_sys) disable iff (reset)
        drive_we |=> liu_ctl.buildout_select_out == $past(wdata[lcsp_pkg::LCSP_BIT_BUILDOUT]))
        else $error("buildout select does not follow written bit");
    chk_reset_clear: assert property (@(posedge clk_sys)
        reset |=> drive_q == lcsp_pkg::LCSP_DRIVE_RESET)
        else $error("drive register not cleared by reset");
endmodule

// ---- logic/lcsp_port.sv ----
// Line interface control and status port for all channels of the framer.
// Assumes the host interface decodes the channel and gives one-cycle write strobes.
// Function
// - Writing one to drive bit 1 raises the local loopback output.
// - Scan bit 1 shows the lock lost input level after a two-stage synchroniser.
// - Encoder disable output follows drive bit 3.
// - In E3 the build-out select is a general output from the control bit.
// - The out of frame flag is high while the framer has lost frame sync.
// - The out of frame flag drops once the framer is aligned again.
// - With packet mode on, received packet bit 1 goes out on nibble bit 1.
// - Each nibble output changes only on the payload clock update edge or on reset.
`timescale 1ns/1ns
module lcsp_port #(
    parameter int CHANNELS = lcsp_pkg::LCSP_NUM_CHANNELS,
    parameter int NIB_W    = lcsp_pkg::LCSP_NIBBLE_W
) (
    input  wire logic                                clk_sys,
    input  wire logic                                reset,
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    input  wire logic [7:0]                          reg_addr,
    input  wire logic [$clog2(CHANNELS)-1:0]         reg_chan,
    input  wire logic [7:0]                          reg_wdata,
    output logic [7:0]                               reg_rdata,
    input  wire logic [CHANNELS-1:0]                 rx_lock_lost_in,
    input  wire logic [CHANNELS-1:0]                 frame_lost,
    input  wire logic [CHANNELS-1:0]                 hdlc_enable,
    input  wire logic [CHANNELS-1:0]                 nib_update,
    input  wire logic [CHANNELS-1:0][NIB_W-1:0]      nib_data,
    input  wire logic [CHANNELS-1:0][NIB_W-1:0]      pkt_data,
    output lcsp_pkg::lcsp_liu_ctl_t [CHANNELS-1:0]   liu_ctl,
    output logic [CHANNELS-1:0]                      rx_frame_lost_flag,
    output logic [CHANNELS-1:0][NIB_W-1:0]           rx_quad_bit_out
);
    // A single channel would leave the channel select without bits.
    if (CHANNELS < 2 || NIB_W <= lcsp_pkg::LCSP_PKT_BIT) begin : g_bad_params
        $error("lcsp_port: unsupported parameters");
    end

    logic [CHANNELS-1:0][7:0] drive_q;
    logic [CHANNELS-1:0][7:0] scan_q;
    logic [7:0]               rdata_ff, nxt_rdata;

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    // independent channel copies
    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
        lcsp_channel #(.NIB_W(NIB_W)) u_chan (
            .clk_sys            (clk_sys),
            .reset              (reset),
            .drive_we           (reg_wr && reg_addr == lcsp_pkg::LCSP_OFS_DRIVE
                                 && reg_chan == c),
            .wdata              (reg_wdata),
            .rx_lock_lost_in    (rx_lock_lost_in[c]),
            .frame_lost         (frame_lost[c]),
            .hdlc_enable        (hdlc_enable[c]),
            .nib_update         (nib_update[c]),
            .nib_data           (nib_data[c]),
            .pkt_data           (pkt_data[c]),
            .drive_q            (drive_q[c]),
            .scan_q             (scan_q[c]),
            .liu_ctl            (liu_ctl[c]),
            .rx_frame_lost_flag (rx_frame_lost_flag[c]),
            .rx_quad_bit_out    (rx_quad_bit_out[c])
        );
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Unmapped offsets and channels read as zero so software sees no stale data.
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            nxt_rdata = 8'h00;
            if (int'(reg_chan) < CHANNELS) begin
                case (reg_addr)
                    lcsp_pkg::LCSP_OFS_DRIVE: nxt_rdata = drive_q[reg_chan];
                    lcsp_pkg::LCSP_OFS_SCAN:  nxt_rdata = scan_q[reg_chan];
                    default:                  nxt_rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    chk_scan_read_back: assert property (@(posedge clk_sys) disable iff (reset)
        reg_rd && reg_addr == lcsp_pkg::LCSP_OFS_SCAN && int'(reg_chan) < CHANNELS
        |=> reg_rdata == $past(scan_q[reg_chan]))
        else $error("scan read does not return lock state");
    chk_drive_read_back: assert property (@(posedge clk_sys) disable iff (reset)
        reg_rd && reg_addr == lcsp_pkg::LCSP_OFS_DRIVE && int'(reg_chan) < CHANNELS
        |=> reg_rdata == $past(drive_q[reg_chan]))
        else $error("drive read does not return register contents");
endmodule

// ---- shared/lcsp_pkg.sv ----
// Package for the line interface control and status port.
// Assumes a byte-wide register port with a channel select from the host interface.
package lcsp_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] LCSP_OFS_DRIVE     = 8'h80;
    localparam logic [7:0] LCSP_OFS_SCAN      = 8'h81;
    localparam logic [7:0] LCSP_DRIVE_RESET   = 8'h00;
    localparam int         LCSP_BIT_LOOPBACK  = 1;
    localparam int         LCSP_BIT_BUILDOUT  = 2;
    localparam int         LCSP_BIT_ENCDIS    = 3;
    localparam int         LCSP_BIT_LOCKLOST  = 1;
    localparam int         LCSP_NUM_CHANNELS  = 6;
    localparam int         LCSP_NIBBLE_W      = 4;
    localparam int         LCSP_PKT_BIT       = 1;

    // Per-channel pins toward the line interface unit.
    typedef struct packed {
        logic local_loopback_out;
        logic encoder_disable_out;
        logic buildout_select_out;
    } lcsp_liu_ctl_t;
endpackage
